// ==== rtl/pdu_pkg.sv ====
// Purpose: Constants for the PWM duty and dead-time unit
// Assumes: Registers sit on 32-bit classic Wishbone, one word each
// Notes: Offsets below are byte addresses
package pdu_pkg;
  localparam int PDU_CH = 4;
  localparam int PDU_DUTY_W = 14;
  localparam int PDU_CNT_W = 12;
  localparam int PDU_DEAD_W = 6;
  // Register byte addresses
  localparam logic [5:0] PDU_ADR_DUTY_LO0 = 6'h00;
  localparam logic [5:0] PDU_ADR_DUTY_HI0 = 6'h04;
  localparam logic [5:0] PDU_ADR_DUTY_LO3 = 6'h18;
  localparam logic [5:0] PDU_ADR_DUTY_HI3 = 6'h1C;
  localparam logic [5:0] PDU_ADR_CTRL0 = 6'h20;
  localparam logic [5:0] PDU_ADR_DTCTL = 6'h24;
  localparam logic [5:0] PDU_ADR_STATUS = 6'h28;
  localparam logic [5:0] PDU_ADR_ACTIVE0 = 6'h30;
  // Field layout
  localparam int PDU_HI_W = 6;
  localparam int PDU_LO_W = 8;
  localparam int PDU_DEADPS_LSB = 6;
  // Reset values
  localparam logic [3:0] PDU_CTRL0_RST = 4'h0;
  localparam logic [7:0] PDU_DTCTL_RST = 8'h00;
  localparam logic [13:0] PDU_DUTY_RST = 14'h0000;
  // Time-base modes
  localparam logic [1:0] PDU_MODE_FREE = 2'h0;
  localparam logic [1:0] PDU_MODE_SHOT = 2'h1;
  localparam logic [1:0] PDU_MODE_UPDN = 2'h2;
  localparam logic [1:0] PDU_MODE_DUPD = 2'h3;
  localparam logic [1:0] PDU_PS_1TO1 = 2'h0;
  // Dead-time prescaler: /2,/4,/8,/16 of the oscillator
  localparam logic [3:0] PDU_DEADPS_MAX0 = 4'h1;
  localparam logic [3:0] PDU_DEADPS_MAX1 = 4'h3;
  localparam logic [3:0] PDU_DEADPS_MAX2 = 4'h7;
  localparam logic [3:0] PDU_DEADPS_MAX3 = 4'hF;
endpackage : pdu_pkg

// ==== rtl/pdu_unit.sv ====
// Purpose: Four-channel duty compare, complementary pairing, dead time
// Assumes: clk_i is the oscillator; phase_i gives the quarter of the cycle
// Notes: Time base lives outside and feeds count, period, direction, mode
`timescale 1ns/1ps
`default_nettype none
module pdu_unit
  import pdu_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Time base link
  input wire logic [11:0] timebase_count_i,
  input wire logic [11:0] period_value_i,
  input wire logic count_direction_flag_i,
  input wire logic timebase_enable_i,
  input wire logic [1:0] timebase_mode_field_i,
  input wire logic [1:0] timebase_prescale_i,
  input wire logic [1:0] phase_i,
  // Output pins: bit 2n+1 main, bit 2n complement
  output logic [7:0] pwm_o
);

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  logic [13:0] duty_buf [PDU_CH];
  // Register map, one 32-bit word per register, byte addresses:
  //   0x00 + 8n  duty n low byte, bits 7:0
  //   0x04 + 8n  duty n high byte, bits 5:0 hold duty bits 13:8
  //   0x20       pair mode bits 3:0, set means independent
  //   0x24       dead-time control: 7:6 prescale, 5:0 count
  //   0x28       status, read only: 3:0 compare, 7:4 dead time busy
  //   0x30 + 4n  active duty n, read only
  // Unmapped words read as zero and ignore writes.
  // Only byte lane 0 carries writable bits, so writes need sel bit 0.
  // Ack is registered and lasts one cycle; a request is not taken
  // while ack stands, so a held strobe cannot write twice.
  logic [13:0] duty_act [PDU_CH];
  logic [3:0] pair_mode;
  logic [7:0] dead_ctl;
  logic [PDU_CH-1:0] cmp;
  logic [PDU_CH-1:0] dead_busy;
  logic req;
  logic wr;
  logic dead_wr;
  logic [31:0] next_dat;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign dead_wr = wr && (wb_adr_i == PDU_ADR_DTCTL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pair_mode <= PDU_CTRL0_RST;
      dead_ctl <= PDU_DTCTL_RST;
    end else if (wr) begin
      if (wb_adr_i == PDU_ADR_CTRL0) begin
        pair_mode <= wb_dat_i[3:0];
      end else if (wb_adr_i == PDU_ADR_DTCTL) begin
        dead_ctl <= wb_dat_i[7:0];
      end
    end
  end

  always_comb begin
    next_dat = 32'h0000_0000;
    if (wb_adr_i <= PDU_ADR_DUTY_HI3 && wb_adr_i[1:0] == 2'h0) begin
      if (wb_adr_i[2]) begin
        next_dat[5:0] = duty_buf[wb_adr_i[4:3]][13:8];
      end else begin
        next_dat[7:0] = duty_buf[wb_adr_i[4:3]][7:0];
      end
    end else if (wb_adr_i == PDU_ADR_CTRL0) begin
      next_dat[3:0] = pair_mode;
    end else if (wb_adr_i == PDU_ADR_DTCTL) begin
      next_dat[7:0] = dead_ctl;
    end else if (wb_adr_i == PDU_ADR_STATUS) begin
      next_dat[7:0] = {dead_busy, cmp};
    end else if (wb_adr_i >= PDU_ADR_ACTIVE0 && wb_adr_i[1:0] == 2'h0) begin
      next_dat[13:0] = duty_act[2'(wb_adr_i[3:2])];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= next_dat;
    end
  end

  // ---------------------------------------------------------------
  // Buffer transfer timing
  // ---------------------------------------------------------------
  // Only the active copy feeds the comparators, so a half-written
  // duty value never reaches the pins. Software may write low and
  // high bytes in any order between transfers.
  // Transfer points by time-base mode:
  //   disabled      every cycle, so a stopped unit tracks its buffers
  //   edge modes    while the count equals the period
  //   up/down       at zero, first cycle after the turn to counting up
  //   double update at zero as above and at the period
  // The period test stands for several cycles; repeated copies of an
  // unchanged buffer are harmless.
  logic centered;
  logic at_zero;
  logic at_period;
  logic count_up;
  logic xfer;
  logic dir_q;
  logic ps_1to1;

  assign centered = timebase_mode_field_i[1];
  assign ps_1to1 = (timebase_prescale_i == PDU_PS_1TO1);
  assign at_zero = (timebase_count_i == 12'h000);
  assign at_period = (timebase_count_i == period_value_i);
  assign count_up = !count_direction_flag_i;

  // Direction from previous cycle shows the turn at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_q <= 1'b0;
    end else begin
      dir_q <= count_direction_flag_i;
    end
  end

  always_comb begin
    xfer = 1'b0;
    if (!timebase_enable_i) begin
      xfer = 1'b1;
    end else if (!centered) begin
      xfer = at_period;
    end else if (timebase_mode_field_i == PDU_MODE_UPDN) begin
      xfer = at_zero && count_up && dir_q;
    end else begin
      xfer = (at_zero && count_up && dir_q) || at_period;
    end
  end

  // ---------------------------------------------------------------
  // Per-channel compare and dead time
  // ---------------------------------------------------------------
  // Dead time is counted in prescaler ticks. The prescaler divides
  // the oscillator by 2, 4, 8 or 16; one tick is a one-cycle pulse.
  // Limitation: one prescaler serves all four pairs, so an edge on
  // one pair restarts the tick train for the others too. A pair that
  // is already counting may then see one stretched tick. Four private
  // prescalers would avoid that at the cost of three more counters.
  logic [3:0] dead_div;
  logic [3:0] dead_max;
  logic dead_tick;
  logic any_edge;
  logic [PDU_CH-1:0] edge_hit;

  // Terminal count of the prescaler for each setting
  always_comb begin
    case (dead_ctl[PDU_DEADPS_LSB +: 2])
      2'h0: dead_max = PDU_DEADPS_MAX0;
      2'h1: dead_max = PDU_DEADPS_MAX1;
      2'h2: dead_max = PDU_DEADPS_MAX2;
      default: dead_max = PDU_DEADPS_MAX3;
    endcase
  end

  assign any_edge = |edge_hit;
  assign dead_tick = (dead_div == dead_max);

  // Shared prescaler; a restart on any edge keeps the first step full
  // A write of the control word restarts it as well, so a new setting
  // never inherits a partly run step of the old one.
  always_ff @(posedge clk_i) begin
    if (rst_i || dead_wr || any_edge) begin
      dead_div <= 4'h0;
    end else if (dead_tick) begin
      dead_div <= 4'h0;
    end else begin
      dead_div <= dead_div + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Per-channel logic
  // ---------------------------------------------------------------
  // Each pass of the loop holds one duty channel and its pin pair:
  // buffer and active register, comparator, edge detector, dead-time
  // counter and the registered output stage.
  // Pin outputs lag the compare state by two cycles in complementary
  // mode; independent pairs skip prev_q and lag by one cycle.
  genvar g;
  generate
    for (g = 0; g < PDU_CH; g++) begin : g_ch
      logic [11:0] dhi;
      logic match;
      logic cmp_q;
      logic [5:0] dead_cnt;
      logic main_q;
      logic comp_q;
      logic hi_wr;
      logic lo_wr;

      assign hi_wr = wr &&
        (wb_adr_i == PDU_ADR_DUTY_HI0 + 6'(8 * g));
      assign lo_wr = wr &&
        (wb_adr_i == PDU_ADR_DUTY_LO0 + 6'(8 * g));

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          duty_buf[g] <= PDU_DUTY_RST;
        end else if (hi_wr) begin
          duty_buf[g][13:8] <= wb_dat_i[PDU_HI_W-1:0];
        end else if (lo_wr) begin
          duty_buf[g][7:0] <= wb_dat_i[PDU_LO_W-1:0];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          duty_act[g] <= PDU_DUTY_RST;
        end else if (xfer) begin
          duty_act[g] <= duty_buf[g];
        end
      end

      // ---------------------------------------------------------
      // Compare
      // ---------------------------------------------------------
      // Upper twelve bits meet the count; the low two bits place the
      // match in one quarter of the instruction cycle, giving two
      // extra bits of resolution at 1:1 prescale.
      // Full-on and full-off tests come first, so a duty outside the
      // period never produces a stray match pulse.
      // The compare state is forced low while the time base is off,
      // so every start begins from an inactive main output.
      assign dhi = duty_act[g][13:2];
      // Phase checked at 1:1, else first phase of the cycle
      assign match = (dhi == timebase_count_i) && (ps_1to1 ?
        (phase_i == duty_act[g][1:0]) : (phase_i == 2'h0));

      always_ff @(posedge clk_i) begin
        if (rst_i || !timebase_enable_i) begin
          cmp_q <= 1'b0;
        end else if (!centered) begin
          if (dhi == 12'h000) begin
            cmp_q <= 1'b0;
          end else if (dhi > period_value_i) begin
            cmp_q <= 1'b1;
          end else if (match) begin
            cmp_q <= 1'b0;
          end else if (at_zero) begin
            cmp_q <= 1'b1;
          end
        end else begin
          if (dhi == 12'h000) begin
            cmp_q <= 1'b0;
          end else if (dhi >= period_value_i) begin
            cmp_q <= 1'b1;
          end else if (match) begin
            cmp_q <= count_direction_flag_i;
          end
        end
      end
      assign cmp[g] = cmp_q;

      // ---------------------------------------------------------
      // Edge detect and dead time
      // ---------------------------------------------------------
      // Idle level after reset is low, matching the compare state,
      // so no false edge follows reset.
      logic prev_q;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          prev_q <= 1'b0;
        end else begin
          prev_q <= cmp_q;
        end
      end
      assign edge_hit[g] = (prev_q != cmp_q) && !pair_mode[g];

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          dead_cnt <= 6'h00;
        end else if (edge_hit[g]) begin
          dead_cnt <= dead_ctl[PDU_DEAD_W-1:0];
        end else if (dead_tick && dead_cnt != 6'h00) begin
          dead_cnt <= dead_cnt - 6'h01;
        end
      end
      // The edge cycle itself counts as busy, so even a zero dead
      // time leaves one cycle with both pins off: the pins are
      // registered and would otherwise swap in one step.
      assign dead_busy[g] = edge_hit[g] || (dead_cnt != 6'h00);

      // ---------------------------------------------------------
      // Output stage
      // ---------------------------------------------------------
      // Both pins drop at once on any edge; after the count runs out
      // the delayed pin follows the compare state. The pin that turns
      // off is never delayed, which keeps switch overlap impossible.
      // Independent pairs bypass dead time and mirror the compare.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          main_q <= 1'b0;
          comp_q <= 1'b0;
        end else if (pair_mode[g]) begin
          main_q <= cmp_q;
          comp_q <= cmp_q;
        end else if (dead_busy[g]) begin
          main_q <= 1'b0;
          comp_q <= 1'b0;
        end else begin
          main_q <= prev_q;
          comp_q <= !prev_q;
        end
      end
      assign pwm_o[2*g+1] = main_q;
      assign pwm_o[2*g] = comp_q;
    end
  endgenerate

endmodule : pdu_unit
`default_nettype wire

// ==== verif/pdu_bridge_model.sv ====
// Purpose: Half-bridge switch pairs fed by the unit's pins
// Assumes: Pin 2n+1 drives the upper switch, pin 2n the lower
// Notes: Flags stay set until reset
`timescale 1ns/1ps
`default_nettype none
module pdu_bridge_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Gate drive and shoot-through flags
  input wire logic [7:0] gate_i,
  output logic [3:0] overlap_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overlap_o <= 4'h0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        // Both switches on shorts the supply
        if (gate_i[2*n+1] && gate_i[2*n]) overlap_o[n] <= 1'b1;
      end
    end
  end
endmodule : pdu_bridge_model
`default_nettype wire

// ==== verif/pdu_unit_checker.sv ====
// Purpose: Bus and pin-pair assertions for pdu_unit
// Assumes: Pair mode and duty 0 buffer tracked from bus writes
// Notes: Bound to every pdu_unit
`timescale 1ns/1ps
`default_nettype none
module pdu_unit_checker
  import pdu_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Time base and pins
  input wire logic timebase_enable_i,
  input wire logic [7:0] pwm_o
);
  logic [3:0] md;
  logic [13:0] buf0;
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wr = req && wb_we_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) md <= 4'h0;
    else if (wr && wb_adr_i == PDU_ADR_CTRL0) md <= wb_dat_i[3:0];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) buf0 <= 14'h0000;
    else if (wr && wb_adr_i == 6'h00) buf0[7:0] <= wb_dat_i[7:0];
    else if (wr && wb_adr_i == 6'h04) buf0[13:8] <= wb_dat_i[5:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_hole_zero: assert property (req && !wb_we_i && wb_adr_i == 6'h2C
    |=> wb_dat_o == 32'h0) else $error("hole read nonzero");
  a_idle_copy: assert property (req && !wb_we_i &&
    wb_adr_i == PDU_ADR_ACTIVE0 && !timebase_enable_i &&
    !$past(timebase_enable_i) |=> wb_dat_o[13:0] == buf0)
    else $error("active not copied");
  a_no_overlap: assert property ((pwm_o & (pwm_o >> 1) &
    {1'b0, ~md[3], 1'b0, ~md[2], 1'b0, ~md[1], 1'b0, ~md[0]}) == 8'h00)
    else $error("pair overlap");
  a_main_waits: assert property (!md[0] && $fell(pwm_o[0]) |-> !pwm_o[1])
    else $error("main on too soon");
  a_comp_waits: assert property (!md[0] && $fell(pwm_o[1]) |-> !pwm_o[0])
    else $error("comp on too soon");
  a_indep_same: assert property (md[0] && $past(md[0], 4)
    |-> pwm_o[1] == pwm_o[0]) else $error("independent pins differ");
endmodule : pdu_unit_checker
bind pdu_unit pdu_unit_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .timebase_enable_i(timebase_enable_i),
  .pwm_o(pwm_o));
`default_nettype wire

// ==== verif/tb_pwm_duty_deadtime_unit.sv ====
// Purpose: Self-checking bench for pdu_unit
// Assumes: Bench plays the time base, phase steps every clock
// Notes: Short period keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_duty_deadtime_unit;
  import pdu_pkg::*;
  localparam int PER = 63;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b0, dir = 1'b0, ack;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [11:0] cnt = 12'h000;
  logic [1:0] ph = 2'h0, tm = 2'h0, ps = 2'h0;
  logic [7:0] pwm;
  logic [3:0] ovl;
  int n_errors = 0, n_tests = 0, m0, b0, hm, hc, lb;
  always #20 clk_i = ~clk_i;
  // Time base: count steps once per four phases
  always @(posedge clk_i) begin
    ph <= ph + 2'h1;
    if (!en) begin
      cnt <= 12'h000;
      dir <= 1'b0;
    end else if (ph == 2'h3) begin
      if (!tm[1]) cnt <= (cnt == 12'(PER)) ? 12'h000 : cnt + 12'h001;
      else if (dir) begin
        dir <= (cnt != 12'h001);
        cnt <= cnt - 12'h001;
      end else begin
        dir <= (cnt == 12'(PER - 1));
        cnt <= cnt + 12'h001;
      end
    end
  end
  pdu_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timebase_count_i(cnt), .period_value_i(12'(PER)),
    .count_direction_flag_i(dir), .timebase_enable_i(en),
    .timebase_mode_field_i(tm), .timebase_prescale_i(ps),
    .phase_i(ph), .pwm_o(pwm));
  pdu_bridge_model i_sw (.clk_i(clk_i), .rst_i(rst_i), .gate_i(pwm),
    .overlap_o(ovl));
  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (i >= 40) begin
      n_errors++;
      wrap_up();
    end
  endtask : wb
  task automatic waitc(input int c, input logic d);
    int i;
    for (i = 0; i < 2000 && !(cnt == 12'(c) && dir == d); i++) @(posedge clk_i);
    if (i >= 2000) begin
      n_errors++;
      wrap_up();
    end
  endtask : waitc
  task automatic cfg(input logic [13:0] d, input logic [7:0] t);
    wb(1'b1, 6'h00, 32'(d[7:0]));
    wb(1'b1, 6'h04, 32'(d[13:8]));
    wb(1'b1, PDU_ADR_DTCTL, 32'(t));
  endtask : cfg
  function automatic int sp();
    return tm[1] ? 8 * PER : 4 * (PER + 1);
  endfunction : sp
  // One period and eight clocks to settle, then one period counted
  task automatic meas;
    en <= 1'b1;
    repeat (sp() + 8) @(posedge clk_i);
    hm = 0;
    hc = 0;
    lb = 0;
    repeat (sp()) begin
      @(posedge clk_i);
      hm += int'(pwm[1]);
      hc += int'(pwm[0]);
      lb += int'(pwm[1:0] == 2'b00);
    end
    en <= 1'b0;
  endtask : meas
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(32'(pwm), 32'h55);
    wb(1'b0, PDU_ADR_CTRL0, 0);
    chk(q, 0);
    for (int n = 0; n < 4; n++) begin
      wb(1'b1, 6'(8 * n), 32'hA0 + 32'(n));
      wb(1'b1, 6'(8 * n + 4), 32'hFF);
      wb(1'b0, 6'(48 + 4 * n), 0);
      chk(q, 32'h3FA0 + 32'(n));
      wb(1'b1, 6'(8 * n), 0);
      wb(1'b1, 6'(8 * n + 4), 0);
    end
    wb(1'b0, 6'h2C, 0);
    chk(q, 0);
    for (int m = 0; m < 4; m++) begin
      tm <= 2'(m);
      cfg(14'h0000, 8'h01);
      meas();
      chk(hm, 0);
      chk(hc, sp());
      cfg(14'((PER + 1) * 4), 8'h01);
      meas();
      chk(hm, sp());
    end
    tm <= 2'h0;
    for (int p = 0; p < 4; p++) begin
      cfg(14'h0080, {2'(p), 6'(16 >> p)});
      meas();
      if (p == 0) m0 = hm;
      if (p == 0) b0 = lb;
      chk(hm, m0);
      chk(lb, b0);
    end
    cfg(14'h0080, 8'h08);
    meas();
    chk(hm, m0 + 16);
    chk(lb, b0 - 32);
    chk(hm + hc + lb, sp());
    cfg(14'h0083, 8'h08);
    meas();
    chk(hm, m0 + 19);
    ps <= 2'h1;
    cfg(14'h0083, 8'h08);
    meas();
    chk(hm, m0 + 16);
    ps <= 2'h0;
    for (int m = 0; m < 4; m++) begin
      tm <= 2'(m);
      cfg(14'h0080, 8'h08);
      en <= 1'b1;
      waitc(10, 1'b0);
      wb(1'b1, 6'h00, 32'h40);
      waitc(PER - 10, 1'(m > 1));
      wb(1'b0, PDU_ADR_ACTIVE0, 0);
      chk(q, m == 3 ? 32'h40 : 32'h80);
      waitc(10, 1'b0);
      wb(1'b0, PDU_ADR_ACTIVE0, 0);
      chk(q, 32'h40);
      en <= 1'b0;
    end
    chk(32'(ovl), 0);
    tm <= 2'h0;
    wb(1'b1, PDU_ADR_CTRL0, 32'h1);
    cfg(14'h0080, 8'h08);
    meas();
    chk(hm, hc);
    chk(lb, sp() - hm);
    chk(32'(ovl[0]), 1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(32'(pwm), 32'h55);
    wb(1'b0, PDU_ADR_CTRL0, 0);
    chk(q, 0);
    wrap_up();
  end
endmodule : tb_pwm_duty_deadtime_unit
`default_nettype wire
